// ### host_model.sv
// host side: character clock and per-channel words
`timescale 1ns/1ns
module host_model
(
	output logic lclk,
	output txin_pkg::tx_word_t [3:0] word
);
	import txin_pkg::*;
	logic [1:0] ph = 2'h0;
	assign lclk = ph[1];
	initial
	begin
		word = '0;
		#130;
		forever
		begin
			#200;
			ph <= ph + 2'h1;
			// words move 600 ns after the rise, clear of the capture window
			if (ph == 2'h0)
				for (int i = 0; i < 4; i++)
					word[i] <= tx_word_t'(word[i] + 10'(i + 1));
		end
	end
endmodule

// ### tb_top.sv
// testbench for the transmit input port
`timescale 1ns/1ns
module tb_top;
	import txin_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic lclk;
	logic gate = 1'b0;
	logic il;
	logic [3:0] ck;
	logic [3:0] txo;
	tx_word_t [3:0] word;
	enc_char_t [3:0] char_out;
	logic [3:0] valid;
	logic [3:0] fault;
	logic irq;
	logic [31:0] q;
	int n_errors = 0;
	int cmp_count = 0;
	int caps;
	always #50 pclk = ~pclk;
	assign ck = {4{lclk}};
	// one source for host and device clocks; gating stops channel 0 reads and overfills its buffer
	assign txo = {ck[3:1], ck[0] & ~gate};
	host_model host_model_inst (.lclk(lclk), .word(word));
	tx_input_port tx_input_port_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .host_tx_clock(ck),
		.chan_reference_clock(ck), .tx_clock_out(txo), .tx_word_in(word),
		.tx_char_out(char_out), .tx_char_valid(valid),
		.tx_fault_out(fault), .irq(irq)
	);
	task stop_test;
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// s picks fault (1) or capture strobe (0); counts channel 2 captures
	task wait_on(input int s, input int c, input logic lvl);
		bit found;
		found = 1'b0;
		for (int n = 0; n < 9000; n++)
		begin
			@(negedge pclk);
			if (valid[2] === 1'b1)
				caps++;
			if ((s ? fault[c] : valid[c]) === lvl)
			begin
				found = 1'b1;
				break;
			end
		end
		if (!found)
		begin
			n_errors++;
			$display("CHECK FAILED %0t wait ran out", $time);
		end
	endtask
	initial
	begin
		#6_000_000;
		n_errors++;
		stop_test();
	end
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, CFG_BASE, '0);
		chk(q, {23'h0, CFG_RESET});
		apb(1'b0, STAT_ADDR, '0);
		chk(q, 32'h0000_0000);
		apb(1'b0, 12'h01C, '0);
		chk(q, 32'h0000_0000);
		for (int m = 0; m < 2; m++)
		begin
			apb(1'b1, 12'h00C, m ? 32'h0000_0075 : 32'h0000_0076);
			wait_on(0, 3, 1'b1);
			wait_on(0, 3, 1'b0);
			wait_on(0, 3, 1'b1);
			chk(char_out[3].is_coded, 32'(m));
			chk(32'(char_out[3].bits), 32'(word[3]));
			if (m == 0)
				chk(char_out[3].kind, KIND_RAW);
			else
				chk(char_out[3].kind, word[3].ctrl == 2'h0 ? KIND_DATA
					: word[3].ctrl == 2'h1 ? KIND_SPECIAL
					: KIND_REPLACE);
		end
		gate <= 1'b1;
		wait_on(1, 0, 1'b1);
		chk(fault[0], 32'h1);
		apb(1'b0, STAT_ADDR, '0);
		chk(q[0], 32'h1);
		apb(1'b1, MASK_ADDR, 32'h0000_00FF);
		@(negedge pclk);
		il = irq;
		apb(1'b1, MASK_ADDR, 32'h0000_0000);
		@(negedge pclk);
		chk(irq ^ il, 32'h1);
		gate <= 1'b0;
		repeat (80) @(negedge pclk);
		chk(fault[0], 32'h1);
		apb(1'b1, CFG_BASE, 32'h0000_0034);
		wait_on(1, 0, 1'b0);
		chk(fault[0], 32'h0);
		apb(1'b1, STAT_ADDR, 32'h0000_00FF);
		apb(1'b0, STAT_ADDR, '0);
		chk(q[0], 32'h0);
		chk(irq, 32'h0);
		apb(1'b1, CFG_STRIDE, 32'h0000_0044);
		repeat (3) @(negedge pclk);
		apb(1'b0, FAULT_ADDR, '0);
		chk(q[1], 32'h1);
		apb(1'b1, CFG_STRIDE, 32'h0000_0074);
		wait_on(1, 1, 1'b0);
		chk(fault[1], 32'h0);
		for (int m = 0; m < 2; m++)
		begin
			apb(1'b1, 12'h008, m ? 32'h0000_0071 : 32'h0000_0079);
			wait_on(1, 2, 1'b1);
			wait_on(1, 2, 1'b0);
			wait_on(1, 2, 1'b1);
			caps = 0;
			wait_on(1, 2, 1'b0);
			wait_on(1, 2, 1'b1);
			chk(32'(caps), m ? 32'd527 : 32'd511);
		end
		apb(1'b1, 12'h008, 32'h0000_0074);
		stop_test();
	end
endmodule

// ### tx_input_port.sv
// four-channel transmit parallel input port with apb configuration
`timescale 1ns/1ns
module tx_input_port
	import txin_pkg::*;
#(
	parameter int NCH = txin_pkg::NUM_CHAN
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [txin_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NCH-1:0] host_tx_clock,
	input wire logic [NCH-1:0] chan_reference_clock,
	input wire logic [NCH-1:0] tx_clock_out,
	input wire txin_pkg::tx_word_t [NCH-1:0] tx_word_in,
	output txin_pkg::enc_char_t [NCH-1:0] tx_char_out,
	output logic [NCH-1:0] tx_char_valid,
	output logic [NCH-1:0] tx_fault_out,
	output logic irq
);
	import txin_pkg::*;

	logic [CFG_W-1:0] cfg_r [NCH];
	logic [1:0] stat_r [NCH];
	logic [1:0] mask_r [NCH];
	logic [NCH-1:0] wr_en;
	logic [NCH-1:0] pab_rst_pulse;
	logic [NCH-1:0] fault_evt;
	logic [NCH-1:0] pass_evt;
	logic setup_ok;

	function automatic enc_char_t encode(input tx_word_t w, input logic byp);
		enc_char_t e;
		e.bits = {w.ctrl, w.chr};
		e.is_coded = ~byp;
		if (byp)
			e.kind = KIND_RAW;
		else if (w.ctrl == 2'h0)
			e.kind = KIND_DATA;
		else if (w.ctrl == 2'h1)
			e.kind = KIND_SPECIAL;
		else
			e.kind = KIND_REPLACE;
		return e;
	endfunction

	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] b);
		return a == b;
	endfunction

	assign pready = 1'b1;
	assign setup_ok = psel && penable;

	// apb slave, zero wait states
	// read data is combinational so no wait state is needed;
	// the price is a longer paddr to prdata path
	// unmapped offsets read zero; those at or above 0x010 also flag pslverr
	always_comb
	begin
		prdata = 32'h0000_0000;
		pslverr = 1'b0;
		wr_en = '0;
		for (int c = 0; c < NCH; c++)
		begin
			if (hit(paddr, CFG_BASE + ADDR_W'(c) * CFG_STRIDE))
			begin
				prdata = 32'(cfg_r[c]);
				wr_en[c] = setup_ok && pwrite;
			end
		end
		if (hit(paddr, STAT_ADDR))
		begin
			for (int c = 0; c < NCH; c++)
				prdata[2*c +: 2] = stat_r[c];
		end
		else if (hit(paddr, MASK_ADDR))
		begin
			for (int c = 0; c < NCH; c++)
				prdata[2*c +: 2] = mask_r[c];
		end
		else if (hit(paddr, FAULT_ADDR))
			prdata = 32'(tx_fault_out);
		else if (paddr >= CFG_BASE + ADDR_W'(NCH) * CFG_STRIDE)
			pslverr = setup_ok;
	end

	// config write; sync bit is self-clearing request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int c = 0; c < NCH; c++)
				cfg_r[c] <= CFG_RESET;
			pab_rst_pulse <= '0;
		end
		else
		begin
			for (int c = 0; c < NCH; c++)
			begin
				pab_rst_pulse[c] <= wr_en[c] && !pwdata[F_PABRST_N];
				if (wr_en[c])
					cfg_r[c] <= pwdata[CFG_W-1:0] & CFG_WMASK
						| (CFG_W'(pwdata[F_SYNC]) << F_SYNC);
				else
					cfg_r[c][F_SYNC] <= 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int c = 0; c < NCH; c++)
				mask_r[c] <= 2'h0;
		else if (setup_ok && pwrite && hit(paddr, MASK_ADDR))
			for (int c = 0; c < NCH; c++)
				mask_r[c] <= pwdata[2*c +: 2];
	end

	// sticky status, write one to clear, set wins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			for (int c = 0; c < NCH; c++)
				stat_r[c] <= 2'h0;
		else
			for (int c = 0; c < NCH; c++)
			begin
				if (setup_ok && pwrite && hit(paddr, STAT_ADDR))
					stat_r[c] <= (stat_r[c] & ~pwdata[2*c +: 2])
						| {pass_evt[c], fault_evt[c]};
				else
					stat_r[c] <= stat_r[c] | {pass_evt[c], fault_evt[c]};
			end
	end

	always_comb
	begin
		irq = 1'b0;
		for (int c = 0; c < NCH; c++)
			irq = irq | |(stat_r[c] & mask_r[c]);
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : chan
			logic [2:0] hclk_s, rclk_s, oclk_s;
			logic hclk_rise, rclk_rise, rclk_fall, oclk_rise;
			logic cap_evt;
			logic [2:0] fill_r;
			logic buf_fault_r;
			logic [9:0] bist_cnt_r;
			logic bist_pulse_r;
			logic [CFG_W-1:0] cf;
			logic pll_down;

			assign cf = cfg_r[g];
			// three-stage sync; stage 0 feeds only stage 1
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					hclk_s <= 3'h0;
					rclk_s <= 3'h0;
					oclk_s <= 3'h0;
				end
				else
				begin
					hclk_s <= {hclk_s[1:0], host_tx_clock[g]};
					rclk_s <= {rclk_s[1:0], chan_reference_clock[g]};
					oclk_s <= {oclk_s[1:0], tx_clock_out[g]};
				end
			end
			assign hclk_rise = hclk_s[1] && !hclk_s[2];
			assign rclk_rise = rclk_s[1] && !rclk_s[2];
			assign rclk_fall = !rclk_s[1] && rclk_s[2];
			assign oclk_rise = oclk_s[1] && !oclk_s[2];
			// capture edge selection
			assign cap_evt = cf[F_CLKSEL] ? (rclk_rise
				|| (cf[F_HALFRATE] && rclk_fall)) : hclk_rise;

			// input register and encoder hand-off
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					tx_char_out[g] <= '0;
					tx_char_valid[g] <= 1'b0;
				end
				else
				begin
					tx_char_valid[g] <= cap_evt;
					if (cap_evt)
						tx_char_out[g] <= encode(tx_word_in[g],
							cf[F_BYPASS]);
				end
			end

			// phase-align buffer fill: host writes, transmit clock reads;
			// only modelled in host-clock mode, reference mode is aligned
			// coincident write and read leave the fill level alone;
			// a fault stays set until re-centred while the level keeps moving, so
			// a drifting host clock cannot clear it by itself
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					fill_r <= PAB_CENTRE;
					buf_fault_r <= 1'b0;
				end
				else if (pab_rst_pulse[g] || cf[F_SYNC])
				begin
					fill_r <= PAB_CENTRE;
					buf_fault_r <= 1'b0;
				end
				else if (!cf[F_CLKSEL] && (cap_evt != oclk_rise))
				begin
					if (cap_evt && fill_r == PAB_MAX)
						buf_fault_r <= 1'b1;
					else if (oclk_rise && fill_r == 3'h0)
						buf_fault_r <= 1'b1;
					else if (cap_evt)
						fill_r <= fill_r + 3'h1;
					else
						fill_r <= fill_r - 3'h1;
				end
			end

			// self-test pass counter in character times
			// pulse stands until the next capture: one character wide
			// limitation: counts captures, not transmit clock periods
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					bist_cnt_r <= 10'h0;
					bist_pulse_r <= 1'b0;
				end
				else if (cf[F_BIST_N])
				begin
					bist_cnt_r <= 10'h0;
					bist_pulse_r <= 1'b0;
				end
				else if (cap_evt)
				begin
					if (bist_cnt_r >= (cf[F_RXCKSEL] ? BIST_LEN_RX1
						: BIST_LEN_RX0) - 10'h1)
					begin
						bist_cnt_r <= 10'h0;
						bist_pulse_r <= 1'b1;
					end
					else
					begin
						bist_cnt_r <= bist_cnt_r + 10'h1;
						bist_pulse_r <= 1'b0;
					end
				end
			end

			assign pll_down = !cf[F_OE1] && !cf[F_OE2];
			assign fault_evt[g] = buf_fault_r && !tx_fault_out[g];
			assign pass_evt[g] = cap_evt && bist_pulse_r && !cf[F_BIST_N];

			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					tx_fault_out[g] <= 1'b0;
				else if (pll_down)
					tx_fault_out[g] <= 1'b1;
				else if (!cf[F_BIST_N])
					tx_fault_out[g] <= bist_pulse_r;
				else
					tx_fault_out[g] <= buf_fault_r;
			end
		end
	endgenerate
endmodule

// ### tx_port_monitor.sv
// pin-level checks of the transmit input port
`timescale 1ns/1ns
module tx_port_monitor
	import txin_pkg::*;
#(
	parameter int NCH = 4
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [txin_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire txin_pkg::tx_word_t [NCH-1:0] tx_word_in,
	input wire txin_pkg::enc_char_t [NCH-1:0] tx_char_out,
	input wire logic [NCH-1:0] tx_char_valid,
	input wire logic [NCH-1:0] tx_fault_out,
	input wire logic irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic rd;
	assign acc = psel && penable;
	assign rd = acc && !pwrite;
	sequence cap_gap_s;
		tx_char_valid[0] ##1 !tx_char_valid[0] [*5];
	endsequence
	sequence pass_pulse_s;
		tx_fault_out[2] [*6] ##[1:3] !tx_fault_out[2];
	endsequence
	chk_one_capture: assert property (
		tx_char_valid[0] |-> cap_gap_s) else $error("captures too close");
	chk_char_bits: assert property (
		tx_char_valid[0] |-> tx_char_out[0].bits == tx_word_in[0])
		else $error("captured character differs");
	chk_chan_alone: assert property (
		tx_char_valid[3] |-> tx_char_out[3].bits == tx_word_in[3])
		else $error("channel 3 character differs");
	chk_zero_wait: assert property (acc |-> pready)
		else $error("bus answer late");
	chk_unmapped_err: assert property (acc && paddr == 12'h01C |-> pslverr)
		else $error("no error on unmapped address");
	chk_unmapped_zero: assert property (rd && paddr == 12'h01C |-> prdata == 0)
		else $error("unmapped read not zero");
	chk_fault_read: assert property (
		rd && paddr == FAULT_ADDR |-> prdata[NCH-1:0] == tx_fault_out)
		else $error("fault register differs from pins");
	chk_fault_hold: assert property (
		$rose(tx_fault_out[0]) |-> tx_fault_out[0] [*8])
		else $error("buffer fault dropped early");
	chk_pass_width: assert property (
		$rose(tx_fault_out[2]) |-> pass_pulse_s)
		else $error("pass pulse not one character");
	chk_irq_idle: assert property (
		rd && paddr == STAT_ADDR && prdata == 0 |-> !irq)
		else $error("interrupt with no status");
endmodule
bind tx_input_port tx_port_monitor #(.NCH(NCH)) tx_port_monitor_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .tx_word_in(tx_word_in), .tx_char_out(tx_char_out),
	.tx_char_valid(tx_char_valid), .tx_fault_out(tx_fault_out), .irq(irq)
);

// ### txin_pkg.sv
// shared constants, register map and carrier types for the transmit input port
package txin_pkg;
	localparam int NUM_CHAN = 4;
	localparam int ADDR_W = 12;
	// register byte addresses
	localparam logic [11:0] CFG_BASE = 12'h000;
	localparam logic [11:0] STAT_ADDR = 12'h010;
	localparam logic [11:0] MASK_ADDR = 12'h014;
	localparam logic [11:0] FAULT_ADDR = 12'h018;
	localparam logic [11:0] CFG_STRIDE = 12'h004;
	// per-channel config word fields
	localparam int F_CLKSEL = 0;
	localparam int F_BYPASS = 1;
	localparam int F_BIST_N = 2;
	localparam int F_RXCKSEL = 3;
	localparam int F_OE1 = 4;
	localparam int F_OE2 = 5;
	localparam int F_PABRST_N = 6;
	localparam int F_HALFRATE = 7;
	localparam int F_SYNC = 8;
	localparam int CFG_W = 9;
	// reset: host clock capture, encoder on, bist off, outputs enabled
	localparam logic [8:0] CFG_RESET = 9'h07_4;
	localparam logic [8:0] CFG_WMASK = 9'h0FF;
	// self-test pass spacing in character times
	localparam logic [9:0] BIST_LEN_RX1 = 10'h1_FF;
	localparam logic [9:0] BIST_LEN_RX0 = 10'h2_0F;
	// phase-align buffer depth and centre
	localparam logic [2:0] PAB_CENTRE = 3'h4;
	localparam logic [2:0] PAB_MAX = 3'h7;
	// status bits
	localparam int ST_FAULT = 0;
	localparam int ST_PASS = 1;
	typedef struct packed {
		logic [1:0] ctrl;
		logic [7:0] chr;
	} tx_word_t;
	typedef struct packed {
		logic [9:0] bits;
		logic is_coded;
		logic [1:0] kind;
	} enc_char_t;
	typedef enum logic [1:0] {
		KIND_DATA = 2'h0,
		KIND_SPECIAL = 2'h1,
		KIND_REPLACE = 2'h3,
		KIND_RAW = 2'h2
	} char_kind_t;
endpackage
